// file: rtl/ufcdr_top.sv
// Status flags with read-then-access clearing, DMA request lines and interrupt logic of a serial port
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "ufcdr_cfg.svh"
module ufcdr_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic [ADDR_W-1:0]    regAddr,
    input  wire ufcdr_pkg::ufcdr_word_t regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output ufcdr_pkg::ufcdr_word_t    regRdata,
    input  wire logic                 rxCharValid,
    input  wire ufcdr_pkg::ufcdr_byte_t rxChar,
    input  wire logic                 rxParityErr,
    input  wire logic                 txCharTaken,
    output ufcdr_pkg::ufcdr_byte_t    txData,
    output logic                      txLoad,
    output logic                      rxDmaReq,
    output logic                      txDmaReq,
    output logic                      irq
);
    import ufcdr_pkg::*;

    localparam logic [ADDR_W-1:0] OFF_STATUS = ADDR_W'(`UFCDR_FIRST_STATUS_OFF);
    localparam logic [ADDR_W-1:0] OFF_DATA   = ADDR_W'(`UFCDR_DATA_OFF);
    localparam logic [ADDR_W-1:0] OFF_CTRL   = ADDR_W'(`UFCDR_CTRL_OFF);
    localparam logic [ADDR_W-1:0] OFF_ISTAT  = ADDR_W'(`UFCDR_INT_STATUS_OFF);
    localparam logic [ADDR_W-1:0] OFF_IMASK  = ADDR_W'(`UFCDR_INT_MASK_OFF);

    // ==========================================================
    // Reset release
    logic nrstSync;

    ufcdr_rst_sync u_rst_sync (
        .clk      (clk),
        .nrst     (nrst),
        .nrstSync (nrstSync)
    );

    // ==========================================================
    // Address decode
    function automatic ufcdr_reg_e decodeReg(input logic [ADDR_W-1:0] a);
        ufcdr_reg_e sel;
        sel = UFCDR_SEL_NONE;
        if (a == OFF_STATUS) begin
            sel = UFCDR_SEL_STATUS;
        end else if (a == OFF_DATA) begin
            sel = UFCDR_SEL_DATA;
        end else if (a == OFF_CTRL) begin
            sel = UFCDR_SEL_CTRL;
        end else if (a == OFF_ISTAT) begin
            sel = UFCDR_SEL_INT_STATUS;
        end else if (a == OFF_IMASK) begin
            sel = UFCDR_SEL_INT_MASK;
        end
        return sel;
    endfunction : decodeReg

    ufcdr_reg_e                 rdSel;
    ufcdr_reg_e                 wrSel;
    logic                       statusRd;
    logic                       dataRd;
    logic                       dataWr;
    logic                       dataAcc;

    always_comb begin
        rdSel    = regRd ? decodeReg(regAddr) : UFCDR_SEL_NONE;
        wrSel    = regWr ? decodeReg(regAddr) : UFCDR_SEL_NONE;
        statusRd = (rdSel == UFCDR_SEL_STATUS);
        dataRd   = (rdSel == UFCDR_SEL_DATA);
        dataWr   = (wrSel == UFCDR_SEL_DATA);
        dataAcc  = dataRd || dataWr;
    end

    // ==========================================================
    // Status flags and clear sequence
    logic                        transmitDataEmptyFlag;
    logic                        receiveDataFullFlag;
    logic                        parityErrorFlag;
    logic [`UFCDR_FLAG_W-1:0]    flagVec;
    logic [`UFCDR_FLAG_W-1:0]    armed;
    logic [`UFCDR_FLAG_W-1:0]    clearVec;
    logic [`UFCDR_FLAG_W-1:0]    next_armed;
    logic                        next_transmitDataEmptyFlag;
    logic                        next_receiveDataFullFlag;
    logic                        next_parityErrorFlag;
    ufcdr_byte_t                 rxHold;
    ufcdr_byte_t                 next_rxHold;

    always_comb begin
        flagVec = '0;
        flagVec[`UFCDR_TX_EMPTY_BIT] = transmitDataEmptyFlag;
        flagVec[`UFCDR_RX_FULL_BIT]  = receiveDataFullFlag;
        flagVec[`UFCDR_PARITY_BIT]   = parityErrorFlag;
        // Only flags seen by the status read are armed; later sets survive the data access
        next_armed = armed;
        if (statusRd) begin
            next_armed = flagVec;
        end else if (dataAcc) begin
            next_armed = '0;
        end
        // Every armed flag goes at once, whatever the access was meant for
        clearVec = dataAcc ? armed : '0;
        // A new event in the clearing cycle wins over the clear
        next_receiveDataFullFlag   = (receiveDataFullFlag & ~clearVec[`UFCDR_RX_FULL_BIT]) | rxCharValid;
        next_parityErrorFlag       = (parityErrorFlag & ~clearVec[`UFCDR_PARITY_BIT])
                                     | (rxCharValid & rxParityErr);
        next_transmitDataEmptyFlag = (transmitDataEmptyFlag & ~clearVec[`UFCDR_TX_EMPTY_BIT]) | txCharTaken;
        next_rxHold = rxCharValid ? rxChar : rxHold;
    end

    always_ff @(posedge clk or negedge nrstSync) begin
        if (!nrstSync) begin
            armed                 <= '0;
            transmitDataEmptyFlag <= 1'(`UFCDR_FLAG_RST >> `UFCDR_TX_EMPTY_BIT);
            receiveDataFullFlag   <= 1'b0;
            parityErrorFlag       <= 1'b0;
            rxHold                <= '0;
        end else begin
            armed                 <= next_armed;
            transmitDataEmptyFlag <= next_transmitDataEmptyFlag;
            receiveDataFullFlag   <= next_receiveDataFullFlag;
            parityErrorFlag       <= next_parityErrorFlag;
            rxHold                <= next_rxHold;
        end
    end

    // ==========================================================
    // Control, transmit load and DMA requests
    logic [`UFCDR_CTRL_W-1:0]  ctrl;
    logic [`UFCDR_CTRL_W-1:0]  next_ctrl;
    ufcdr_byte_t               next_txData;
    logic                      next_txLoad;
    logic                      next_rxDmaReq;
    logic                      next_txDmaReq;

    always_comb begin
        next_ctrl   = ctrl;
        next_txData = txData;
        next_txLoad = 1'b0;
        if (wrSel == UFCDR_SEL_CTRL) begin
            next_ctrl = regWdata[`UFCDR_CTRL_W-1:0];
        end
        if (dataWr) begin
            next_txData = regWdata[7:0];
            next_txLoad = 1'b1;
        end
        // Built from next values so the line falls in the same cycle as its flag
        next_rxDmaReq = next_receiveDataFullFlag & next_ctrl[`UFCDR_RX_DMA_EN_BIT];
        next_txDmaReq = next_transmitDataEmptyFlag & next_ctrl[`UFCDR_TX_DMA_EN_BIT];
    end

    always_ff @(posedge clk or negedge nrstSync) begin
        if (!nrstSync) begin
            ctrl     <= `UFCDR_CTRL_RST;
            txData   <= '0;
            txLoad   <= 1'b0;
            rxDmaReq <= 1'b0;
            txDmaReq <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            txData   <= next_txData;
            txLoad   <= next_txLoad;
            rxDmaReq <= next_rxDmaReq;
            txDmaReq <= next_txDmaReq;
        end
    end

    // ==========================================================
    // Interrupt status, mask and read data
    logic [`UFCDR_INT_W-1:0]  intStatus;
    logic [`UFCDR_INT_W-1:0]  intMask;
    logic [`UFCDR_INT_W-1:0]  intEvent;
    logic [`UFCDR_INT_W-1:0]  next_intStatus;
    logic [`UFCDR_INT_W-1:0]  next_intMask;
    logic                     next_irq;
    ufcdr_word_t              next_regRdata;

    always_comb begin
        intEvent = '0;
        intEvent[`UFCDR_INT_RX_BIT]  = rxCharValid;
        intEvent[`UFCDR_INT_TX_BIT]  = txCharTaken;
        intEvent[`UFCDR_INT_PAR_BIT] = rxCharValid & rxParityErr;
        // A late DMA read of an empty data register returns the old byte, is flagged and still clears any armed flag
        intEvent[`UFCDR_INT_UFL_BIT] = dataRd & ~receiveDataFullFlag;
        next_intStatus = intStatus;
        next_intMask   = intMask;
        if (wrSel == UFCDR_SEL_INT_STATUS) begin
            next_intStatus = intStatus & ~regWdata[`UFCDR_INT_W-1:0];
        end
        if (wrSel == UFCDR_SEL_INT_MASK) begin
            next_intMask = regWdata[`UFCDR_INT_W-1:0];
        end
        next_intStatus = next_intStatus | intEvent;
        next_irq       = |(next_intStatus & next_intMask);
        next_regRdata  = '0;
        case (rdSel)
            UFCDR_SEL_STATUS: begin
                next_regRdata[`UFCDR_FLAG_W-1:0] = flagVec;
            end
            UFCDR_SEL_DATA: begin
                next_regRdata[7:0] = rxHold;
            end
            UFCDR_SEL_CTRL: begin
                next_regRdata[`UFCDR_CTRL_W-1:0] = ctrl;
            end
            UFCDR_SEL_INT_STATUS: begin
                next_regRdata[`UFCDR_INT_W-1:0] = intStatus;
            end
            UFCDR_SEL_INT_MASK: begin
                next_regRdata[`UFCDR_INT_W-1:0] = intMask;
            end
            default: begin
                next_regRdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrstSync) begin
        if (!nrstSync) begin
            intStatus <= '0;
            intMask   <= `UFCDR_INT_MASK_RST;
            irq       <= 1'b0;
            regRdata  <= '0;
        end else begin
            intStatus <= next_intStatus;
            intMask   <= next_intMask;
            irq       <= next_irq;
            regRdata  <= next_regRdata;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrstSync);

    sequence statusThenDataRead;
        (statusRd && parityErrorFlag && receiveDataFullFlag) ##1 (dataRd && !rxCharValid);
    endsequence

    sequence statusThenDataAccess;
        (statusRd && receiveDataFullFlag) ##1 (dataAcc && !rxCharValid);
    endsequence

    sequence statusThenTxAccess;
        (statusRd && transmitDataEmptyFlag) ##1 (dataAcc && !txCharTaken);
    endsequence

    sequence unarmedRxAccess;
        dataAcc && !armed[`UFCDR_RX_FULL_BIT] && receiveDataFullFlag;
    endsequence

    rxReqTrack_a: assert property (rxDmaReq == (receiveDataFullFlag && ctrl[`UFCDR_RX_DMA_EN_BIT]))
        else $error("rx DMA request does not follow flag and enable");
    txReqTrack_a: assert property (txDmaReq == (transmitDataEmptyFlag && ctrl[`UFCDR_TX_DMA_EN_BIT]))
        else $error("tx DMA request does not follow flag and enable");
    onlySeqClear_a: assert property ($fell(receiveDataFullFlag) |-> $past(dataAcc) && $past(armed[`UFCDR_RX_FULL_BIT]))
        else $error("receive full flag cleared without read sequence");
    noWriteClear_a: assert property ((wrSel == UFCDR_SEL_STATUS) && !armed[`UFCDR_TX_EMPTY_BIT]
                                     && transmitDataEmptyFlag |=> transmitDataEmptyFlag)
        else $error("direct write cleared a flag");
    parityClear_a: assert property (statusThenDataRead |=> !parityErrorFlag && !receiveDataFullFlag)
        else $error("parity clear sequence left a flag set");
    reqDrop_a: assert property (statusThenDataAccess ##0 ctrl[`UFCDR_RX_DMA_EN_BIT] |=> !rxDmaReq)
        else $error("rx DMA request stayed after clear sequence");
    setWins_a: assert property (rxCharValid |=> receiveDataFullFlag && (parityErrorFlag || !$past(rxParityErr))
                                && rxHold == $past(rxChar))
        else $error("received character lost its flag");
    irqLevel_a: assert property (irq == |(intStatus & intMask))
        else $error("interrupt output does not match status and mask");

    // The clear cannot tell which flag software meant, so transmit empty goes too
    txSideClear_a: assert property (statusThenTxAccess |=> !transmitDataEmptyFlag)
        else $error("transmit empty flag survived clear sequence");
    unarmedKeep_a: assert property (unarmedRxAccess |=> receiveDataFullFlag)
        else $error("data access cleared a flag the status read never saw");
    armedSnap_a: assert property (statusRd |=> armed == $past(flagVec))
        else $error("status read armed the wrong flags");
    disarm_a: assert property (dataAcc |=> armed == '0)
        else $error("data access left flags armed");

    // Event inputs must always leave their flag set one cycle later
    paritySet_a: assert property (rxCharValid && rxParityErr |=> parityErrorFlag)
        else $error("parity mismatch did not set the parity flag");
    txSetWins_a: assert property (txCharTaken |=> transmitDataEmptyFlag)
        else $error("consumed character did not set transmit empty");

    // A late DMA read is tolerated: it returns the old byte, raises a status bit and still clears any armed flag
    lateRead_a: assert property (dataRd && !receiveDataFullFlag |=> intStatus[`UFCDR_INT_UFL_BIT])
        else $error("read of an empty data register was not flagged");

    // Bus side: the load pulse and read data stand for exactly one cycle
    txLoadPulse_a: assert property (dataWr |=> txLoad && txData == $past(regWdata[7:0]))
        else $error("data write did not load the transmitter");
    txLoadOnce_a: assert property (!dataWr |=> !txLoad)
        else $error("transmit load pulse without a data write");
    rdataIdle_a: assert property (!regRd |=> regRdata == '0)
        else $error("read data shown without a read");
endmodule : ufcdr_top

// file: rtl/ufcdr_cfg.svh
// Offsets, field positions and reset values of the flag-clear and DMA request block
`ifndef UFCDR_CFG_SVH
`define UFCDR_CFG_SVH

// ==========================================================
// Register offsets
`define UFCDR_FIRST_STATUS_OFF 8'h00
`define UFCDR_DATA_OFF         8'h04
`define UFCDR_CTRL_OFF         8'h08
`define UFCDR_INT_STATUS_OFF   8'h0C
`define UFCDR_INT_MASK_OFF     8'h10

// ==========================================================
// First status register fields
`define UFCDR_TX_EMPTY_BIT  0
`define UFCDR_RX_FULL_BIT   1
`define UFCDR_PARITY_BIT    2
`define UFCDR_FLAG_W        3

// ==========================================================
// Control register fields
`define UFCDR_RX_DMA_EN_BIT 0
`define UFCDR_TX_DMA_EN_BIT 1
`define UFCDR_CTRL_W        2

// ==========================================================
// Interrupt status and mask fields
`define UFCDR_INT_RX_BIT    0
`define UFCDR_INT_TX_BIT    1
`define UFCDR_INT_PAR_BIT   2
`define UFCDR_INT_UFL_BIT   3
`define UFCDR_INT_W         4

// ==========================================================
// Reset values
`define UFCDR_FLAG_RST      3'h1
`define UFCDR_CTRL_RST      2'h0
`define UFCDR_INT_MASK_RST  4'h0

`endif

// file: rtl/ufcdr_pkg.sv
// Types shared by the flag-clear and DMA request block
package ufcdr_pkg;
    typedef logic [7:0] ufcdr_byte_t;
    typedef logic [31:0] ufcdr_word_t;
    typedef enum {
        UFCDR_SEL_STATUS,
        UFCDR_SEL_DATA,
        UFCDR_SEL_CTRL,
        UFCDR_SEL_INT_STATUS,
        UFCDR_SEL_INT_MASK,
        UFCDR_SEL_NONE
    } ufcdr_reg_e;
endpackage : ufcdr_pkg

// file: rtl/ufcdr_rst_sync.sv
// Two-stage release synchroniser for the asynchronous active-low reset
`timescale 1ns/1ps
module ufcdr_rst_sync (
    input  wire logic clk,
    input  wire logic nrst,
    output logic      nrstSync
);
    logic stage1;

    // ==========================================================
    // Assert at once, release after two edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1   <= 1'b0;
            nrstSync <= 1'b0;
        end else begin
            stage1   <= 1'b1;
            nrstSync <= stage1;
        end
    end
endmodule : ufcdr_rst_sync

// file: verification/ufcdr_dma_model.sv
// Behavioural model of the DMA channel that serves the receive request line
`timescale 1ns/1ps
`include "ufcdr_cfg.svh"
module ufcdr_dma_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       req,
    input  wire logic [3:0] latency,
    output logic            dmaRd,
    output logic [7:0]      dmaAddr
);
    logic       reqPrev;
    logic       pending;
    logic [3:0] count;

    // ==========================================================
    // One transfer per request edge taken while no transfer is pending, issued after a set latency
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reqPrev <= 1'b0;
            pending <= 1'b0;
            count   <= 4'h0;
            dmaRd   <= 1'b0;
            dmaAddr <= 8'hFF;
        end else begin
            reqPrev <= req;
            dmaRd   <= 1'b0;
            // Idle address is the inverse of the target, never a stale match
            dmaAddr <= ~`UFCDR_DATA_OFF;
            if (req && !reqPrev && !pending) begin
                pending <= 1'b1;
                count   <= latency;
            end else if (pending && count != 4'h0) begin
                count <= count - 4'h1;
            end else if (pending) begin
                // Prepared on the request edge, so it runs even if the request has gone
                pending <= 1'b0;
                dmaRd   <= 1'b1;
                dmaAddr <= `UFCDR_DATA_OFF;
            end
        end
    end
endmodule : ufcdr_dma_model

// file: verification/uart_flag_clear_dma_request_tb_top.sv
// Self-checking testbench of the flag-clear and DMA request block
`timescale 1ns/1ps
`include "ufcdr_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module uart_flag_clear_dma_request_tb_top;
    import ufcdr_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, tbWr = 1'b0, tbRd = 1'b0, dmaOn = 1'b0, lastLoad;
    logic        rxCharValid = 1'b0, rxParityErr = 1'b0, txCharTaken = 1'b0;
    logic [7:0]  tbAddr = 8'h00, dmaAddr, b;
    ufcdr_byte_t rxChar = 8'h00, txData;
    ufcdr_word_t tbWdata = 32'h0, regRdata, d;
    logic        dmaRd, txLoad, rxDmaReq, txDmaReq, irq;
    int          errors = 0, compares = 0;

    always #5 clk = ~clk;

    ufcdr_top dut (.clk(clk), .nrst(nrst), .regAddr(dmaRd ? dmaAddr : tbAddr), .regWdata(tbWdata),
        .regWr(tbWr), .regRd(tbRd | dmaRd), .regRdata(regRdata), .rxCharValid(rxCharValid), .rxChar(rxChar),
        .rxParityErr(rxParityErr), .txCharTaken(txCharTaken), .txData(txData), .txLoad(txLoad),
        .rxDmaReq(rxDmaReq), .txDmaReq(txDmaReq), .irq(irq));
    ufcdr_dma_model dma (.clk(clk), .nrst(nrst), .req(rxDmaReq & dmaOn), .latency(4'h6),
        .dmaRd(dmaRd), .dmaAddr(dmaAddr));

    // ==========================================================
    // Expectations and bus tasks
    function automatic ufcdr_word_t st(input logic t, input logic r, input logic p);
        return {29'h0, p, r, t};
    endfunction : st

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input ufcdr_word_t v);
        @(posedge clk);
        tbAddr  <= a;
        tbWdata <= v;
        tbWr    <= 1'b1;
        @(posedge clk);
        tbWr <= 1'b0;
        #1 lastLoad = txLoad;
    endtask : wr

    task automatic chkRd(input logic [7:0] a, input ufcdr_word_t e);
        @(posedge clk);
        tbAddr <= a;
        tbRd   <= 1'b1;
        @(posedge clk);
        tbRd <= 1'b0;
        #1 `CHK(regRdata, e)
    endtask : chkRd

    task automatic ev(input logic v, input logic [7:0] c, input logic p, input logic t);
        @(posedge clk);
        rxCharValid <= v;
        rxChar      <= c;
        rxParityErr <= p;
        txCharTaken <= t;
        @(posedge clk);
        rxCharValid <= 1'b0;
        rxParityErr <= 1'b0;
        txCharTaken <= 1'b0;
        #1;
    endtask : ev

    task automatic wrap_up();
        if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        errors++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(58078));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        chkRd(`UFCDR_FIRST_STATUS_OFF, st(1'b1, 1'b0, 1'b0));
        chkRd(`UFCDR_CTRL_OFF, 32'h0);
        chkRd(`UFCDR_INT_MASK_OFF, 32'h0);
        chkRd(8'h20, 32'h0);
        wr(`UFCDR_CTRL_OFF, 32'h3);
        tick();
        `CHK(txDmaReq, 1'b1)
        `CHK(rxDmaReq, 1'b0)
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            wr(`UFCDR_DATA_OFF, {24'h0, ~b});
            `CHK(lastLoad, 1'b1)
            `CHK(txData, ~b)
            // First pass: the write completes the clear armed by the opening status read
            `CHK(txDmaReq, 1'b0)
            ev(1'b0, 8'h00, 1'b0, 1'b1);
            ev(1'b1, (i == 0) ? 8'hFF : b, 1'b0, 1'b0);
            if (i == 0) b = 8'hFF;
            `CHK(rxDmaReq, 1'b1)
            wr(`UFCDR_FIRST_STATUS_OFF, 32'h0);
            chkRd(`UFCDR_DATA_OFF, {24'h0, b});
            chkRd(`UFCDR_FIRST_STATUS_OFF, st(1'b1, 1'b1, 1'b0));
            chkRd(`UFCDR_DATA_OFF, {24'h0, b});
            `CHK({rxDmaReq, txDmaReq}, 2'h0)
            chkRd(`UFCDR_FIRST_STATUS_OFF, st(1'b0, 1'b0, 1'b0));
        end
        b = 8'($urandom);
        wr(`UFCDR_INT_STATUS_OFF, 32'hF);
        wr(`UFCDR_INT_MASK_OFF, 32'h4);
        ev(1'b1, b, 1'b1, 1'b0);
        `CHK(rxDmaReq, 1'b1)
        tick();
        `CHK(irq, 1'b1)
        // Handler stops the request before touching the error flag
        wr(`UFCDR_CTRL_OFF, 32'h0);
        tick();
        `CHK(rxDmaReq, 1'b0)
        chkRd(`UFCDR_FIRST_STATUS_OFF, st(1'b0, 1'b1, 1'b1));
        chkRd(`UFCDR_DATA_OFF, {24'h0, b});
        chkRd(`UFCDR_FIRST_STATUS_OFF, st(1'b0, 1'b0, 1'b0));
        wr(`UFCDR_INT_STATUS_OFF, 32'hF);
        tick();
        `CHK(irq, 1'b0)
        wr(`UFCDR_INT_MASK_OFF, 32'h0);
        wr(`UFCDR_CTRL_OFF, 32'h1);
        dmaOn = 1'b1;
        b = 8'($urandom);
        ev(1'b1, b, 1'b0, 1'b0);
        chkRd(`UFCDR_FIRST_STATUS_OFF, st(1'b0, 1'b1, 1'b0));
        chkRd(`UFCDR_DATA_OFF, {24'h0, b});
        `CHK(rxDmaReq, 1'b0)
        repeat (10) tick();
        chkRd(`UFCDR_INT_STATUS_OFF, 32'h9);
        chkRd(`UFCDR_FIRST_STATUS_OFF, st(1'b0, 1'b0, 1'b0));
        chkRd(`UFCDR_DATA_OFF, {24'h0, b});
        wrap_up();
    end
endmodule : uart_flag_clear_dma_request_tb_top
